// file: rtl/rtp_pkg.sv
package rtp_pkg;

  // ==========================================================
  // Register file geometry
  localparam int NUM_REGS = 8;
  localparam int PTR_W = 3;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  typedef logic [PTR_W-1:0] rtp_ptr_t;
  typedef logic [7:0] rtp_byte_t;

  // ==========================================================
  // Two-wire protocol constants
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hd0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [PTR_W-1:0] PTR_STEP = 3'h1;
  localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
  localparam logic DIR_READ = 1'b1;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_LOW = 1'b0;

  // ==========================================================
  // Protocol states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } rtp_state_e;

endpackage

// file: rtl/rtp_sync2.sv
`timescale 1ns/1ps

// ==========================================================
// Two flip-flop level synchroniser
module rtp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule // rtp_sync2

// file: rtl/rtp_rtc_port.sv
`timescale 1ns/1ps

module rtp_rtc_port (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic LINK_CLK_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic UPD_WR_IN,
  input wire rtp_pkg::rtp_ptr_t UPD_ADDR_IN,
  input wire rtp_pkg::rtp_byte_t UPD_DATA_IN,
  input wire rtp_pkg::rtp_ptr_t CORE_RD_ADDR_IN,
  output rtp_pkg::rtp_byte_t CORE_RD_DATA_OUT,
  output logic BUS_WR_OUT,
  output rtp_pkg::rtp_ptr_t BUS_WR_ADDR_OUT,
  output rtp_pkg::rtp_byte_t BUS_WR_DATA_OUT
);
  import rtp_pkg::*;

  // ==========================================================
  // Link domain: line sampling and bus conditions
  logic scl_s;
  logic sda_s;
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  rtp_sync2 #(.RST_VAL(LINE_IDLE)) u_sync_scl (
    .clk_in(LINK_CLK_IN),
    .rst_in(RST_IN),
    .d_in(SCL_IN),
    .q_out(scl_s)
  );

  rtp_sync2 #(.RST_VAL(LINE_IDLE)) u_sync_sda (
    .clk_in(LINK_CLK_IN),
    .rst_in(RST_IN),
    .d_in(SDA_IN),
    .q_out(sda_s)
  );

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_q_reg <= LINE_IDLE;
      sda_q_reg <= LINE_IDLE;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // ==========================================================
  // Link domain: protocol engine
  rtp_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  rtp_byte_t shift_reg;
  rtp_byte_t tx_shift_reg;
  rtp_byte_t tx_buf_reg;
  rtp_ptr_t ptr_reg;
  logic rw_reg;
  logic have_word_reg;
  logic adv_pending_reg;
  logic sda_oe_reg;
  logic byte_end;
  logic addr_hit;
  logic ack_end;
  logic tx_mid;

  assign byte_end = scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign addr_hit = (shift_reg[7:1] == SLAVE_ADDR_BYTE[7:1]);
  assign ack_end = scl_fall && (state_reg == ST_ACK);
  assign tx_mid = scl_fall && (state_reg == ST_TX) &&
                  (bit_cnt_reg >= FIRST_BIT) && (bit_cnt_reg < BYTE_BITS);

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_ADDR: begin
          if (byte_end) begin
            state_reg <= addr_hit ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_reg <= rw_reg ? ST_TX : ST_RX;
          end
        end
        ST_RX: begin
          if (byte_end) begin
            state_reg <= ST_ACK;
          end
        end
        ST_TX: begin
          if (byte_end) begin
            state_reg <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            state_reg <= ST_IDLE;
          end else if (scl_fall) begin
            state_reg <= ST_TX;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bit_cnt_reg <= CNT_ZERO;
    end else if (start_det || ack_end ||
                 (scl_fall && state_reg == ST_MACK)) begin
      bit_cnt_reg <= CNT_ZERO;
    end else if (scl_rise && (state_reg == ST_ADDR ||
                 state_reg == ST_RX || state_reg == ST_TX)) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_STEP;
    end
  end

  // Incoming bits, MSB first, taken while the clock is high
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shift_reg <= REG_RESET_VAL;
    end else if (scl_rise && (state_reg == ST_ADDR ||
                 state_reg == ST_RX)) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rw_reg <= 1'b0;
      have_word_reg <= 1'b0;
      adv_pending_reg <= 1'b0;
    end else if (state_reg == ST_ADDR && byte_end && addr_hit) begin
      rw_reg <= shift_reg[0];
      adv_pending_reg <= 1'b0;
      if (shift_reg[0] != DIR_READ) begin
        have_word_reg <= 1'b0;
      end
    end else if (state_reg == ST_RX && byte_end) begin
      have_word_reg <= 1'b1;
      adv_pending_reg <= have_word_reg;
    end else if (ack_end) begin
      adv_pending_reg <= 1'b0;
    end
  end

  // Pointer survives between transfers; only reset clears it
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ptr_reg <= PTR_RESET;
    end else if (state_reg == ST_RX && byte_end && !have_word_reg) begin
      ptr_reg <= shift_reg[PTR_W-1:0];
    end else if (ack_end && adv_pending_reg) begin
      ptr_reg <= ptr_reg + PTR_STEP;
    end else if (state_reg == ST_MACK && scl_rise && !sda_s) begin
      ptr_reg <= ptr_reg + PTR_STEP;
    end
  end

  // Outgoing bits change only right after a clock fall
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_shift_reg <= REG_RESET_VAL;
    end else if ((ack_end && rw_reg) ||
                 (scl_fall && state_reg == ST_MACK)) begin
      tx_shift_reg <= {tx_buf_reg[6:0], LINE_IDLE};
    end else if (tx_mid) begin
      tx_shift_reg <= {tx_shift_reg[6:0], LINE_IDLE};
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sda_oe_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (byte_end && ((state_reg == ST_ADDR && addr_hit) ||
                 state_reg == ST_RX)) begin
      sda_oe_reg <= 1'b1;
    end else if (byte_end && state_reg == ST_TX) begin
      sda_oe_reg <= 1'b0;
    end else if ((ack_end && rw_reg) ||
                 (scl_fall && state_reg == ST_MACK)) begin
      sda_oe_reg <= ~tx_buf_reg[7];
    end else if (ack_end) begin
      sda_oe_reg <= 1'b0;
    end else if (tx_mid) begin
      sda_oe_reg <= ~tx_shift_reg[7];
    end else if (state_reg == ST_IDLE) begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign SDA_OUT = LINE_LOW;
  assign SDA_OE_OUT = sda_oe_reg;

  // ==========================================================
  // Link domain: requests to the register file
  logic fetch_tog_reg;
  rtp_ptr_t fetch_addr_reg;
  logic wr_tog_reg;
  rtp_ptr_t wr_addr_reg;
  rtp_byte_t wr_data_reg;
  logic rd_tog_s;
  logic rd_tog_q_reg;
  rtp_byte_t rd_data_reg;
  logic rd_tog_reg;

  // First byte is fetched at the address acknowledge, one bit ahead; later bytes a whole byte time ahead of their use
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fetch_tog_reg <= 1'b0;
      fetch_addr_reg <= PTR_RESET;
    end else if (state_reg == ST_ADDR && byte_end && addr_hit &&
                 shift_reg[0] == DIR_READ) begin
      fetch_tog_reg <= ~fetch_tog_reg;
      fetch_addr_reg <= ptr_reg;
    end else if ((ack_end && rw_reg) ||
                 (scl_fall && state_reg == ST_MACK)) begin
      fetch_tog_reg <= ~fetch_tog_reg;
      fetch_addr_reg <= ptr_reg + PTR_STEP;
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_tog_reg <= 1'b0;
      wr_addr_reg <= PTR_RESET;
      wr_data_reg <= REG_RESET_VAL;
    end else if (state_reg == ST_RX && byte_end && have_word_reg) begin
      wr_tog_reg <= ~wr_tog_reg;
      wr_addr_reg <= ptr_reg;
      wr_data_reg <= shift_reg;
    end
  end

  rtp_sync2 #(.RST_VAL(1'b0)) u_sync_rd (
    .clk_in(LINK_CLK_IN),
    .rst_in(RST_IN),
    .d_in(rd_tog_reg),
    .q_out(rd_tog_s)
  );

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_tog_q_reg <= 1'b0;
      tx_buf_reg <= REG_RESET_VAL;
    end else begin
      rd_tog_q_reg <= rd_tog_s;
      if (rd_tog_s != rd_tog_q_reg) begin
        tx_buf_reg <= rd_data_reg;
      end
    end
  end

  // ==========================================================
  // System domain: register file
  logic fetch_tog_s;
  logic fetch_tog_q_reg;
  logic wr_tog_s;
  logic wr_tog_q_reg;
  logic bus_wr_now;
  rtp_byte_t regs_mem [NUM_REGS];

  rtp_sync2 #(.RST_VAL(1'b0)) u_sync_fetch (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .d_in(fetch_tog_reg),
    .q_out(fetch_tog_s)
  );

  rtp_sync2 #(.RST_VAL(1'b0)) u_sync_wr (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .d_in(wr_tog_reg),
    .q_out(wr_tog_s)
  );

  assign bus_wr_now = (wr_tog_s != wr_tog_q_reg);

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fetch_tog_q_reg <= 1'b0;
      wr_tog_q_reg <= 1'b0;
    end else begin
      fetch_tog_q_reg <= fetch_tog_s;
      wr_tog_q_reg <= wr_tog_s;
    end
  end

  // Bus writes win over a same-cycle update from the core
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_mem[i] <= REG_RESET_VAL;
      end
    end else if (bus_wr_now) begin
      regs_mem[wr_addr_reg] <= wr_data_reg;
    end else if (UPD_WR_IN) begin
      regs_mem[UPD_ADDR_IN] <= UPD_DATA_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_tog_reg <= 1'b0;
      rd_data_reg <= REG_RESET_VAL;
    end else if (fetch_tog_s != fetch_tog_q_reg) begin
      rd_tog_reg <= ~rd_tog_reg;
      rd_data_reg <= regs_mem[fetch_addr_reg];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BUS_WR_OUT <= 1'b0;
      BUS_WR_ADDR_OUT <= PTR_RESET;
      BUS_WR_DATA_OUT <= REG_RESET_VAL;
      CORE_RD_DATA_OUT <= REG_RESET_VAL;
    end else begin
      BUS_WR_OUT <= bus_wr_now;
      CORE_RD_DATA_OUT <= regs_mem[CORE_RD_ADDR_IN];
      if (bus_wr_now) begin
        BUS_WR_ADDR_OUT <= wr_addr_reg;
        BUS_WR_DATA_OUT <= wr_data_reg;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_addr_miss;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (state_reg == ST_ADDR && byte_end && !addr_hit && !start_det &&
     !stop_det) |=> (state_reg == ST_IDLE && !sda_oe_reg);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("unmatched address was answered");

  property p_start;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    start_det |=> (state_reg == ST_ADDR && bit_cnt_reg == CNT_ZERO);
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_stop;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (stop_det && !start_det) |=> (state_reg == ST_IDLE && !sda_oe_reg);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not end the transfer");

  property p_drive_low_clock;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    $rose(sda_oe_reg) |-> !$past(scl_s);
  endproperty
  a_drive_low_clock: assert property (p_drive_low_clock)
    else $error("data drive began while clock high");

  property p_bit_count;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    bit_cnt_reg <= BYTE_BITS;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("more than eight bits in a byte");

  property p_ack_drive;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (byte_end && !start_det && !stop_det &&
     (state_reg == ST_RX || (state_reg == ST_ADDR && addr_hit)))
    |=> (state_reg == ST_ACK && sda_oe_reg);
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("received byte not acknowledged");

  property p_ack_hold;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (state_reg == ST_ACK && scl_s) |-> sda_oe_reg;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released during clock high");

  property p_nack_release;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (state_reg == ST_MACK && scl_rise && sda_s && !stop_det &&
     !start_det) |=> !sda_oe_reg [*4];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data line driven after missing acknowledge");

  property p_word_load;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (state_reg == ST_RX && byte_end && !have_word_reg && !start_det &&
     !stop_det) |=> ptr_reg == $past(shift_reg[PTR_W-1:0]);
  endproperty
  a_word_load: assert property (p_word_load)
    else $error("word address not loaded into pointer");

  property p_read_advance;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (state_reg == ST_MACK && scl_rise && !sda_s && !start_det &&
     !stop_det) |=> ptr_reg == $past(ptr_reg) + PTR_STEP;
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("pointer not advanced on acknowledge");

  property p_tx_first_bit;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    (ack_end && rw_reg && !start_det && !stop_det)
    |=> sda_oe_reg == !$past(tx_buf_reg[7]);
  endproperty
  a_tx_first_bit: assert property (p_tx_first_bit)
    else $error("first read bit not from the fetched byte");

  c_write: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    state_reg == ST_RX && byte_end && have_word_reg);
  c_read_ack: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    state_reg == ST_MACK && scl_rise && !sda_s);
  c_read_nack: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    state_reg == ST_MACK && scl_rise && sda_s);
  c_addr_miss: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    state_reg == ST_ADDR && byte_end && !addr_hit);

endmodule // rtp_rtc_port

// file: verification/rtp_i2c_master.sv
`timescale 1ns/1ps

// ==========================================================
// Two-wire bus master model, stepped on the system clock
module rtp_i2c_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // Clock low 1.6 us in two halves, clock high 0.8 us
  localparam int HALF_LOW = 20;
  localparam int T_HIGH = 20;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Data set mid-low, held through the high period, sampled at its end
  task automatic bit_xfer(input logic b, output logic s);
    wt(HALF_LOW);
    sda_oe_out = ~b;
    wt(HALF_LOW);
    scl_out = 1'b1;
    wt(T_HIGH);
    s = sda_in;
    scl_out = 1'b0;
  endtask

  // Entered with the bus idle or with the clock low after a byte
  task automatic start();
    wt(HALF_LOW);
    sda_oe_out = 1'b0;
    wt(HALF_LOW);
    scl_out = 1'b1;
    wt(T_HIGH);
    sda_oe_out = 1'b1;
    wt(T_HIGH);
    scl_out = 1'b0;
  endtask

  task automatic stop();
    wt(HALF_LOW);
    sda_oe_out = 1'b1;
    wt(HALF_LOW);
    scl_out = 1'b1;
    wt(T_HIGH);
    sda_oe_out = 1'b0;
    wt(2 * HALF_LOW);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, ack);
  endtask

  // Acknowledge every byte but the last, which is left high
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(last, s);
  endtask
endmodule // rtp_i2c_master

// file: verification/tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module tb;
  import rtp_pkg::*;

  typedef struct packed {
    rtp_ptr_t loc;
    rtp_byte_t data;
  } rtp_row_s;

  // ==========================================================
  // Signals
  logic sys_clk, link_clk, rst, upd_wr, scl, m_oe;
  rtp_ptr_t upd_addr, rd_addr, bus_wr_addr, last_addr;
  rtp_byte_t upd_data, rd_data, bus_wr_data, last_data;
  logic sda_out, sda_oe, bus_wr;
  wire sda_line = ((sda_oe && !sda_out) || m_oe) ? 1'b0 : 1'b1;
  int bad_count = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  rtp_row_s rows [0:7] = '{'{3'h0, 8'h59}, '{3'h1, 8'h13},
    '{3'h2, 8'ha5}, '{3'h3, 8'h02}, '{3'h4, 8'h31}, '{3'h5, 8'h12},
    '{3'h6, 8'h24}, '{3'h7, 8'h80}};
  logic [7:0] bad_addr [0:2] = '{8'ha0, 8'hd2, 8'h50};

  rtp_rtc_port rtp_rtc_port_inst (
    .SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK_CLK_IN(link_clk),
    .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE_OUT(sda_oe), .UPD_WR_IN(upd_wr), .UPD_ADDR_IN(upd_addr),
    .UPD_DATA_IN(upd_data), .CORE_RD_ADDR_IN(rd_addr),
    .CORE_RD_DATA_OUT(rd_data), .BUS_WR_OUT(bus_wr),
    .BUS_WR_ADDR_OUT(bus_wr_addr), .BUS_WR_DATA_OUT(bus_wr_data)
  );

  rtp_i2c_master rtp_i2c_master_inst (
    .clk_in(sys_clk), .sda_in(sda_line), .scl_out(scl),
    .sda_oe_out(m_oe)
  );

  // ==========================================================
  // Clocks, write monitor, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  always @(posedge sys_clk) begin
    if (bus_wr === 1'b1) begin
      wr_cnt++;
      last_addr = bus_wr_addr;
      last_data = bus_wr_data;
    end
  end

  initial begin
    #2500000;
    bad_count++;
    finish_test();
  end

  // ==========================================================
  // Tasks
  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic core_rd(input rtp_ptr_t loc, input rtp_byte_t exp);
    rd_addr = loc;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(rd_data, exp)
  endtask

  task automatic wr_seq(input rtp_byte_t ptr, input rtp_byte_t d0,
                        input int n);
    logic ack;
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE, ack);
    `CHK(ack, 1'b0)
    rtp_i2c_master_inst.wbyte(ptr, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < n; i++) begin
      rtp_i2c_master_inst.wbyte(rtp_byte_t'(d0 + i), ack);
      `CHK(ack, 1'b0)
    end
    rtp_i2c_master_inst.stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic ack, s;
    rtp_byte_t d;
    int n0;
    rst = 1'b1;
    upd_wr = 1'b0;
    upd_addr = '0;
    upd_data = '0;
    rd_addr = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK(sda_oe, 1'b0)
    for (int i = 0; i < 8; i++) begin
      core_rd(rtp_ptr_t'(i), REG_RESET_VAL);
    end
    for (int i = 0; i < 8; i++) begin
      n0 = wr_cnt;
      wr_seq({5'h00, rows[i].loc}, rows[i].data, 1);
      `CHK(wr_cnt, n0 + 1)
      `CHK(last_addr, rows[i].loc)
      `CHK(last_data, rows[i].data)
      core_rd(rows[i].loc, rows[i].data);
    end
    // Foreign addresses get no acknowledge and write nothing
    n0 = wr_cnt;
    for (int i = 0; i < 3; i++) begin
      rtp_i2c_master_inst.start();
      rtp_i2c_master_inst.wbyte(bad_addr[i], ack);
      `CHK(ack, 1'b1)
      rtp_i2c_master_inst.wbyte(8'h02, ack);
      `CHK(ack, 1'b1)
      rtp_i2c_master_inst.stop();
    end
    `CHK(wr_cnt, n0)
    // Byte cut short by STOP is dropped
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE, ack);
    rtp_i2c_master_inst.wbyte(8'h02, ack);
    for (int i = 0; i < 4; i++) begin
      rtp_i2c_master_inst.bit_xfer(1'b1, s);
    end
    rtp_i2c_master_inst.stop();
    `CHK(wr_cnt, n0)
    core_rd(3'h2, 8'ha5);
    // Burst across the wrap, upper pointer bits ignored
    wr_seq(8'h0e, 8'hc1, 3);
    `CHK(wr_cnt, n0 + 3)
    `CHK(last_addr, 3'h0)
    `CHK(last_data, 8'hc3)
    core_rd(3'h7, 8'hc2);
    // Core update, then pointer write and repeated-start read
    upd_addr = 3'h4;
    upd_data = 8'h77;
    upd_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    upd_wr = 1'b0;
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE, ack);
    rtp_i2c_master_inst.wbyte(8'h04, ack);
    `CHK(ack, 1'b0)
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE | 8'h01, ack);
    `CHK(ack, 1'b0)
    rtp_i2c_master_inst.rbyte(1'b0, d);
    `CHK(d, 8'h77)
    rtp_i2c_master_inst.rbyte(1'b0, d);
    `CHK(d, 8'h12)
    rtp_i2c_master_inst.rbyte(1'b1, d);
    `CHK(d, 8'hc1)
    rtp_i2c_master_inst.bit_xfer(1'b1, s);
    `CHK(s, 1'b1)
    rtp_i2c_master_inst.stop();
    `CHK(wr_cnt, n0 + 3)
    // Read without pointer write resumes where the last read stopped
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE | 8'h01, ack);
    rtp_i2c_master_inst.rbyte(1'b1, d);
    `CHK(d, 8'hc1)
    rtp_i2c_master_inst.stop();
    // Mid-run reset clears the locations and the stored pointer
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK(sda_oe, 1'b0)
    core_rd(3'h6, REG_RESET_VAL);
    upd_addr = 3'h0;
    upd_data = 8'h5a;
    upd_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    upd_wr = 1'b0;
    rtp_i2c_master_inst.start();
    rtp_i2c_master_inst.wbyte(SLAVE_ADDR_BYTE | 8'h01, ack);
    `CHK(ack, 1'b0)
    rtp_i2c_master_inst.rbyte(1'b1, d);
    `CHK(d, 8'h5a)
    rtp_i2c_master_inst.stop();
    finish_test();
  end
endmodule // tb
